// File: rtl/wcca_pkg.sv
// =============================================
// Shared constants for the write checksum checker
package wcca_pkg;

    // =============================================
    // Frame geometry
    localparam int          LANES       = 18;          // Nine lanes per tree, two trees
    localparam int          TREE_LANES  = 9;
    localparam int          MASK_LANE   = 8;           // Lane index of mask/inversion inside a tree
    localparam int          XFERS       = 10;
    localparam logic [3:0]  LAST_XFER_CRC  = 4'h9;     // Checksum frames are ten transfers
    localparam logic [3:0]  LAST_XFER_RAW  = 4'h7;     // Plain frames are eight transfers
    localparam int          CRC_XFER_LO = 8;
    localparam int          CRC_XFER_HI = 9;
    localparam int          WORD_W      = 72;
    localparam int          X4_DATA_W   = 32;
    localparam int          MASK_BASE   = 64;
    localparam int          ARR_W       = 128;

    // =============================================
    // Checksum code: x^8 + x^2 + x + 1, zero seed
    localparam logic [7:0]  CRC_POLY    = 8'h07;
    localparam logic [7:0]  CRC_SEED    = 8'h00;

    // =============================================
    // Alert timing, in ns and command clock cycles
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          ALERT_LAT_NS   = 13;       // Longest time, rounds down
    localparam int          ALERT_LAT_CYC  = (ALERT_LAT_NS / CLK_PERIOD_NS < 1) ? 1 : ALERT_LAT_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  ALERT_PW_MIN   = 4'h6;
    localparam logic [3:0]  ALERT_PW_MAX   = 4'hA;
    localparam logic [3:0]  ALERT_PW_CYC   = 4'h8;     // Inside the 6..10 window

    // =============================================
    // Register map (byte addresses) and fields
    localparam logic [7:0]  OFS_CFG     = 8'h00;
    localparam logic [7:0]  OFS_MODE5   = 8'h04;
    localparam logic [7:0]  OFS_MULTIPURPOSE_PAGE_REG_THREE    = 8'h08;
    localparam logic [7:0]  OFS_STAT    = 8'h0C;
    localparam int          CFG_WIDTH_LSB = 0;
    localparam int          CFG_CRC_EN    = 2;
    localparam int          CFG_DBI_EN    = 3;
    localparam int          CFG_DM_EN     = 4;
    localparam int          CFG_BC4       = 5;
    localparam logic [5:0]  CFG_RST       = 6'h01;     // x8, checksum off
    localparam int          MODE5_ERR_BIT = 3;
    localparam int          MULTIPURPOSE_PAGE_REG_THREE_ERR_BIT  = 0;

    typedef enum logic [1:0] {
        WCCA_X4  = 2'h0,
        WCCA_X8  = 2'h1,
        WCCA_X16 = 2'h2
    } wcca_width_t;

    typedef enum logic [1:0] {
        WCCA_IDLE  = 2'h0,
        WCCA_RECV  = 2'h1,
        WCCA_CHECK = 2'h3
    } wcca_state_t;

endpackage : wcca_pkg

// File: rtl/wcca_top.sv
// Operation
// - Wide part: two independent trees, lower and upper
// - Lane i: data transfers 0-7, checksum transfer 8
// - Recompute, compare, alert on any mismatch
// - Eight-bit top inputs forced one unless mask/inversion
// - Sixteen-bit top inputs of both trees forced one unless mask/inversion
// - Four-bit part: bits 32 to 71 are ones
// - Full writes commit in the same cycle the check result raises alert
// - Checksum and parity errors share alert output
// - Alert is low pulse of 6-10 cycles
// - Alert starts within 13 ns of error
// - Error sets mode-five and page-three status bits
// - Error clear bit holds until software writes zero
// - Checking enabled by mode bit, full and chopped
// - Checksum frames are exactly ten transfers long
// - Four-bit chop: 16 data bits, split checksum
// - Wide chop: transfers four to seven are ones
// - Code polynomial x^8+x^2+x+1, combinational
// - Zero seed, bit 71 enters first
// - Check raw data, undo inversion only afterwards
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module wcca_top (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Write data link pins
    input  wire logic        link_clk,
    input  wire logic        frame_valid,
    input  wire logic [15:0] dq_lane,
    input  wire logic        lower_mask_lane,
    input  wire logic        upper_mask_lane,
    // Parity alert request from the command/address checker
    input  wire logic        parity_alert,
    // Open-drain alert pin
    output logic             alert_o,
    output logic             alert_oe,
    // Array write port
    output logic [127:0]     arr_wr_data,
    output logic             arr_wr_valid
);

    // =============================================
    // Functions
    // Serial form of the code unrolled by synthesis into the xor trees
    function automatic logic [7:0] wcca_crc8(input logic [71:0] d);
        logic [7:0] c;
        logic       fb;
        c  = wcca_pkg::CRC_SEED;
        fb = 1'b0;
        for (int i = wcca_pkg::WORD_W - 1; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? wcca_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : wcca_crc8

    // Gathers one tree's 72 inputs and forces unused ones high
    function automatic logic [71:0] wcca_word(input logic [9:0][17:0] f, input int t,
                                              input logic x4, input logic bc4, input logic mused);
        logic [71:0] w;
        w = '1;
        for (int j = 0; j < 8; j++) begin
            for (int k = 0; k < 8; k++) begin
                w[8*j+k] = f[k][t*wcca_pkg::TREE_LANES+j];
            end
        end
        for (int k = 0; k < 8; k++) begin
            w[wcca_pkg::MASK_BASE+k] = f[k][t*wcca_pkg::TREE_LANES+wcca_pkg::MASK_LANE];
        end
        if (!mused) begin
            w[71:64] = '1;
        end
        if (x4) begin
            w[71:32] = '1;
        end
        if (bc4) begin
            for (int j = 0; j < 9; j++) begin
                w[8*j+4 +: 4] = '1;
            end
        end
        return w;
    endfunction : wcca_word

    // =============================================
    // Reset release through two flops
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // =============================================
    // Pin synchroniser; stage one feeds stage two only
    logic [19:0] pin_s1_ff;
    logic [19:0] pin_s2_ff;
    logic        link_clk_d_ff;
    logic        link_rise;
    logic        fv_sync;
    logic [17:0] xfer_bits;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff     <= 20'h00000;
            pin_s2_ff     <= 20'h00000;
            link_clk_d_ff <= 1'b0;
        end else begin
            pin_s1_ff     <= {link_clk, frame_valid, upper_mask_lane, dq_lane[15:8], lower_mask_lane, dq_lane[7:0]};
            pin_s2_ff     <= pin_s1_ff;
            link_clk_d_ff <= pin_s2_ff[19];
        end
    end
    // Data rides the same delay as the strobe, so sampling stays aligned
    assign link_rise = pin_s2_ff[19] & ~link_clk_d_ff;
    assign fv_sync   = pin_s2_ff[18];
    assign xfer_bits = pin_s2_ff[17:0];

    // =============================================
    // Configuration and status registers
    logic [5:0] cfg_ff;
    logic       mr5_err_ff;
    logic       multipurpose_page_reg_three_err_ff;
    logic [31:0] prdata_ff;
    logic       crc_en;
    logic       dbi_en;
    logic       mask_used;
    logic       bc4;
    wcca_pkg::wcca_width_t width;

    assign width     = wcca_pkg::wcca_width_t'(cfg_ff[wcca_pkg::CFG_WIDTH_LSB +: 2]);
    assign crc_en    = cfg_ff[wcca_pkg::CFG_CRC_EN];
    assign dbi_en    = cfg_ff[wcca_pkg::CFG_DBI_EN];
    // Both bits set is illegal at the controller; either one enables the lane
    assign mask_used = cfg_ff[wcca_pkg::CFG_DBI_EN] | cfg_ff[wcca_pkg::CFG_DM_EN];
    assign bc4       = cfg_ff[wcca_pkg::CFG_BC4];

    // APB decode
    logic acc_ph, setup_ph, mapped;
    logic hit_cfg, hit_mode5, hit_multipurpose_page_reg_three, hit_stat;
    logic wr_mode5_clr, wr_multipurpose_page_reg_three_clr;

    assign setup_ph     = psel & ~penable;
    assign acc_ph       = psel & penable;
    assign hit_cfg      = paddr == wcca_pkg::OFS_CFG;
    assign hit_mode5    = paddr == wcca_pkg::OFS_MODE5;
    assign hit_multipurpose_page_reg_three     = paddr == wcca_pkg::OFS_MULTIPURPOSE_PAGE_REG_THREE;
    assign hit_stat     = paddr == wcca_pkg::OFS_STAT;
    assign mapped       = hit_cfg | hit_mode5 | hit_multipurpose_page_reg_three | hit_stat;
    assign wr_mode5_clr = acc_ph & pwrite & hit_mode5 & ~pwdata[wcca_pkg::MODE5_ERR_BIT];
    assign wr_multipurpose_page_reg_three_clr  = acc_ph & pwrite & hit_multipurpose_page_reg_three & ~pwdata[wcca_pkg::MULTIPURPOSE_PAGE_REG_THREE_ERR_BIT];
    assign pready       = 1'b1;                                   // Zero wait states
    assign pslverr      = acc_ph & ~mapped;
    assign prdata       = prdata_ff;

    // =============================================
    // Frame receiver
    wcca_pkg::wcca_state_t state_ff;
    wcca_pkg::wcca_state_t nxt_state;
    logic [3:0]       xcnt_ff;
    logic [9:0][17:0] frame_ff;
    logic [3:0]       last_xfer;
    logic             take;

    // Without checksum the frame is eight transfers
    assign last_xfer = crc_en ? wcca_pkg::LAST_XFER_CRC : wcca_pkg::LAST_XFER_RAW;
    assign take      = link_rise & fv_sync;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            wcca_pkg::WCCA_IDLE: begin
                if (take) begin
                    nxt_state = wcca_pkg::WCCA_RECV;
                end
            end
            wcca_pkg::WCCA_RECV: begin
                // A frame that drops its valid early is abandoned unchecked
                if (link_rise && !fv_sync) begin
                    nxt_state = wcca_pkg::WCCA_IDLE;
                end else if (take && xcnt_ff == last_xfer) begin
                    nxt_state = wcca_pkg::WCCA_CHECK;
                end
            end
            wcca_pkg::WCCA_CHECK: begin
                nxt_state = wcca_pkg::WCCA_IDLE;
            end
            default: begin
                nxt_state = wcca_pkg::WCCA_IDLE;
            end
        endcase
    end

    // Transfer capture; slots above the last stay as ones
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= wcca_pkg::WCCA_IDLE;
            xcnt_ff  <= 4'h0;
            frame_ff <= '1;
        end else begin
            state_ff <= nxt_state;
            if (take && state_ff == wcca_pkg::WCCA_IDLE) begin
                frame_ff    <= '1;
                frame_ff[0] <= xfer_bits;
                xcnt_ff     <= 4'h1;
            end else if (take && state_ff == wcca_pkg::WCCA_RECV) begin
                frame_ff[xcnt_ff] <= xfer_bits;
                xcnt_ff           <= xcnt_ff + 4'h1;
            end
        end
    end

    // =============================================
    // Checksum trees and compare, on raw received bits
    logic [71:0] word_lo, word_hi;
    logic [7:0]  calc_lo, calc_hi, rcv_lo, rcv_hi;
    logic        is_x4, is_x16, mismatch, crc_err;

    assign is_x4   = width == wcca_pkg::WCCA_X4;
    assign is_x16  = width == wcca_pkg::WCCA_X16;
    assign word_lo = wcca_word(frame_ff, 0, is_x4, bc4, mask_used);
    assign word_hi = wcca_word(frame_ff, 1, 1'b0, bc4, mask_used);
    assign calc_lo = wcca_crc8(word_lo);
    assign calc_hi = wcca_crc8(word_hi);
    // Four-bit parts split the checksum over transfers eight and nine
    assign rcv_lo  = is_x4 ? {frame_ff[wcca_pkg::CRC_XFER_HI][3:0], frame_ff[wcca_pkg::CRC_XFER_LO][3:0]}
                           : frame_ff[wcca_pkg::CRC_XFER_LO][7:0];
    assign rcv_hi  = frame_ff[wcca_pkg::CRC_XFER_LO][16:9];
    assign mismatch = (|(calc_lo ^ rcv_lo)) | (is_x16 & (|(calc_hi ^ rcv_hi)));
    assign crc_err  = (state_ff == wcca_pkg::WCCA_CHECK) & crc_en & mismatch;

    // =============================================
    // Array write: committed at once, inversion undone here only
    logic [127:0] arr_data_ff;
    logic         arr_valid_ff;
    logic [127:0] nxt_arr_data;

    always_comb begin
        nxt_arr_data = '0;
        for (int l = 0; l < 16; l++) begin
            for (int k = 0; k < 8; k++) begin
                // Inversion lane is active low: zero means the byte was inverted
                nxt_arr_data[8*l+k] = frame_ff[k][l + l/8] ^
                    (dbi_en & ~frame_ff[k][(l/8)*wcca_pkg::TREE_LANES + wcca_pkg::MASK_LANE]);
            end
        end
    end

    // Full writes land in the same cycle that the compare result starts the alert and sets the error bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arr_data_ff  <= 128'h0;
            arr_valid_ff <= 1'b0;
        end else begin
            arr_valid_ff <= state_ff == wcca_pkg::WCCA_CHECK;
            if (state_ff == wcca_pkg::WCCA_CHECK) begin
                arr_data_ff <= nxt_arr_data;
            end
        end
    end
    assign arr_wr_data  = arr_data_ff;
    assign arr_wr_valid = arr_valid_ff;

    // =============================================
    // Alert pulse; a fixed pulse keeps retries cheap at the controller
    logic [3:0] alert_cnt_ff;
    logic       alert_act;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_cnt_ff <= 4'h0;
        end else if (crc_err) begin
            alert_cnt_ff <= wcca_pkg::ALERT_PW_CYC;
        end else if (alert_cnt_ff != 4'h0) begin
            alert_cnt_ff <= alert_cnt_ff - 4'h1;
        end
    end
    assign alert_act = alert_cnt_ff != 4'h0;
    assign alert_o   = 1'b0;                                    // Open drain only pulls low
    assign alert_oe  = alert_act | parity_alert;

    // =============================================
    // Register writes, sticky error bits and read data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff      <= wcca_pkg::CFG_RST;
            mr5_err_ff  <= 1'b0;
            multipurpose_page_reg_three_err_ff <= 1'b0;
            prdata_ff   <= 32'h0;
        end else begin
            if (acc_ph && pwrite && hit_cfg) begin
                cfg_ff <= pwdata[5:0];
            end
            // Set wins over a clear in the same cycle
            if (crc_err) begin
                mr5_err_ff  <= 1'b1;
                multipurpose_page_reg_three_err_ff <= 1'b1;
            end else begin
                if (wr_mode5_clr) begin
                    mr5_err_ff <= 1'b0;
                end
                if (wr_multipurpose_page_reg_three_clr) begin
                    multipurpose_page_reg_three_err_ff <= 1'b0;
                end
            end
            if (setup_ph) begin
                prdata_ff <= 32'h0;
                if (hit_cfg) begin
                    prdata_ff[5:0] <= cfg_ff;
                end
                if (hit_mode5) begin
                    prdata_ff[wcca_pkg::MODE5_ERR_BIT] <= mr5_err_ff;
                end
                if (hit_multipurpose_page_reg_three) begin
                    prdata_ff[wcca_pkg::MULTIPURPOSE_PAGE_REG_THREE_ERR_BIT] <= multipurpose_page_reg_three_err_ff;
                end
                if (hit_stat) begin
                    prdata_ff[7:0] <= {alert_act, state_ff, 1'b0, xcnt_ff};
                end
            end
        end
    end

    // =============================================
    // Assertions
    // A reload during a pulse would stretch it; link speed keeps errors further apart
    property p_alert_width;
        @(posedge sys_clk) disable iff (!rst_n) $rose(alert_act) |-> alert_act[*8] ##1 !alert_act;
    endproperty
    a_alert_width: assert property (p_alert_width) else $error("alert pulse width wrong");
    property p_alert_end;
        @(posedge sys_clk) disable iff (!rst_n) $fell(alert_act) |-> $past(alert_cnt_ff) == 4'h1;
    endproperty
    a_alert_end: assert property (p_alert_end) else $error("alert ended early");
    property p_alert_lat;
        @(posedge sys_clk) disable iff (!rst_n) crc_err |-> ##1 (alert_act && alert_oe);
    endproperty
    a_alert_lat: assert property (p_alert_lat) else $error("alert late after checksum error");
    property p_sticky_set;
        @(posedge sys_clk) disable iff (!rst_n) crc_err |=> mr5_err_ff && multipurpose_page_reg_three_err_ff;
    endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("error bits not set");
    property p_sticky_hold;
        @(posedge sys_clk) disable iff (!rst_n) mr5_err_ff && !wr_mode5_clr |=> mr5_err_ff;
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("error clear bit dropped by itself");
    property p_x4_ones;
        @(posedge sys_clk) disable iff (!rst_n) state_ff == wcca_pkg::WCCA_CHECK && is_x4 |-> &word_lo[71:32];
    endproperty
    a_x4_ones: assert property (p_x4_ones) else $error("four-bit upper inputs not ones");
    property p_mask_ones;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff == wcca_pkg::WCCA_CHECK && !mask_used |-> (&word_lo[71:64]) && (&word_hi[71:64]);
    endproperty
    a_mask_ones: assert property (p_mask_ones) else $error("mask inputs not forced to one");
    property p_bc4_ones;
        @(posedge sys_clk) disable iff (!rst_n) state_ff == wcca_pkg::WCCA_CHECK && bc4
        |-> (&word_lo[7:4]) && (&word_lo[71:68]) && (mask_used || (&word_lo[67:64]));
    endproperty
    a_bc4_ones: assert property (p_bc4_ones) else $error("chopped transfers not ones");
    property p_frame_len;
        @(posedge sys_clk) disable iff (!rst_n) state_ff == wcca_pkg::WCCA_RECV && take && crc_en
        && xcnt_ff == wcca_pkg::LAST_XFER_CRC |=> state_ff == wcca_pkg::WCCA_CHECK;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("ten-transfer frame not checked");
    property p_disabled;
        @(posedge sys_clk) disable iff (!rst_n) !crc_en && !alert_act |=> !alert_act;
    endproperty
    a_disabled: assert property (p_disabled) else $error("alert with checking disabled");
    property p_parity_share;
        @(posedge sys_clk) disable iff (!rst_n) parity_alert |-> alert_oe && !alert_o;
    endproperty
    a_parity_share: assert property (p_parity_share) else $error("parity alert not on shared pin");
    c_crc_err: cover property (@(posedge sys_clk) disable iff (!rst_n) crc_err);
    c_good_frame: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == wcca_pkg::WCCA_CHECK && crc_en && !mismatch);
    c_bc4_x16: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == wcca_pkg::WCCA_CHECK && bc4 && is_x16);

endmodule : wcca_top

// File: bench/wcca_ctrl_model.sv
`timescale 1ns/1ps
// =============================================
// Controller model: builds checksum frames and plays them on the link
module wcca_ctrl_model (
    output logic        link_clk,
    output logic        frame_valid,
    output logic [15:0] dq_lane,
    output logic        lower_mask_lane,
    output logic        upper_mask_lane
);
    // Serial form of the code, one bit a step
    function automatic logic [7:0] crc72(input logic [71:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 71; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc72

    // Link clock stands still between frames
    initial begin
        link_clk = 1'b0;
        frame_valid = 1'b0;
        {upper_mask_lane, lower_mask_lane, dq_lane} = 18'h0;
    end

    // Forced places carry raw data, so a device that forgets to force them fails
    task automatic send(input logic [143:0] d, input logic [5:0] cfg, input logic [1:0] bad, input logic [2:0] bi);
        logic [71:0] w [2];
        logic [7:0]  c [2];
        logic [17:0] b;
        w[0] = d[71:0];
        w[1] = d[143:72];
        for (int k = 0; k < 2; k++) begin
            if (!(cfg[3] | cfg[4])) w[k][71:64] = 8'hFF;
            if (cfg[1:0] == 2'h0) w[k][71:32] = '1;
            for (int l = 0; l < 9; l++) if (cfg[5]) w[k][8*l+4 +: 4] = 4'hF;
            c[k] = crc72(w[k]) ^ ((bad == 2'(k + 1)) ? (8'h01 << bi) : 8'h00);
        end
        for (int t = 0; t < (cfg[2] ? 10 : 8); t++) begin
            for (int l = 0; l < 18; l++) b[l] = (t < 8) ? d[8*l+t] : 1'b1;
            if (t == 8) b = {1'b1, c[1], 1'b1, c[0]};
            if (t >= 8 && cfg[1:0] == 2'h0) b[3:0] = (t == 8) ? c[0][3:0] : c[0][7:4];
            dq_lane = {b[16:9], b[7:0]};
            lower_mask_lane = b[8];
            upper_mask_lane = b[17];
            frame_valid = 1'b1;
            #31.25 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
            #31.25;
        end
        frame_valid = 1'b0;
        dq_lane = ~dq_lane;
        {upper_mask_lane, lower_mask_lane} = ~{upper_mask_lane, lower_mask_lane};
    endtask : send
endmodule : wcca_ctrl_model

// File: bench/wcca_top_tb.sv
`timescale 1ns/1ps
// =============================================
// Bench: register access and checksum frames
module wcca_top_tb;
    logic         sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd;
    logic         pready, pslverr, err, parity_alert = 1'b0, exp_e;
    logic         link_clk, frame_valid, lower_mask_lane, upper_mask_lane, alert_o, alert_oe, arr_wr_valid;
    logic [15:0]  dq_lane;
    logic [127:0] arr_wr_data;
    logic [143:0] d;
    int           error_cnt = 0, checked = 0, cyc = 0, n, m;
    // {corrupt tree, config}; inversion and mask never both on
    logic [7:0]   cases [12] = '{8'h44, 8'h24, 8'h64, 8'h05, 8'h4D, 8'h35, 8'h65, 8'h06, 8'h86, 8'hAE, 8'h16, 8'h41};

    wcca_top        i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk(link_clk), .frame_valid(frame_valid), .dq_lane(dq_lane), .lower_mask_lane(lower_mask_lane),
        .upper_mask_lane(upper_mask_lane), .parity_alert(parity_alert), .alert_o(alert_o), .alert_oe(alert_oe),
        .arr_wr_data(arr_wr_data), .arr_wr_valid(arr_wr_valid));
    wcca_ctrl_model i_ctrl (.link_clk(link_clk), .frame_valid(frame_valid), .dq_lane(dq_lane),
        .lower_mask_lane(lower_mask_lane), .upper_mask_lane(upper_mask_lane));

    // Clock and cycle ceiling
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 50000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, only the cycle ceiling ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic test_done;
        $display("Compares %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, wcca_pkg::OFS_CFG, 32'h0);
        chk(rd, {26'h0, wcca_pkg::CFG_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        @(posedge sys_clk);
        parity_alert <= 1'b1;
        @(posedge sys_clk);
        #1 chk(alert_oe, 1'b1);
        chk(alert_o, 1'b0);
        @(posedge sys_clk);
        parity_alert <= 1'b0;
        foreach (cases[i]) begin
            d = {9{16'h5A0F ^ (16'(i) * 16'h3B1D)}};
            exp_e = (cases[i][7:6] != 2'h0) && cases[i][2];
            apb(1'b1, wcca_pkg::OFS_CFG, {26'h0, cases[i][5:0]});
            n = 0;
            m = 0;
            fork
                i_ctrl.send(d, cases[i][5:0], cases[i][7:6], 3'(i));
                begin
                    do begin
                        @(posedge sys_clk);
                        #1 n++;
                    end while (arr_wr_valid !== 1'b1 && n < 400);
                    while (alert_oe === 1'b1 && m < 20) begin
                        @(posedge sys_clk);
                        #1 m++;
                    end
                end
            join
            chk(n < 400, 1'b1);
            chk(m, exp_e ? wcca_pkg::ALERT_PW_CYC : 0);
            if (i == 7) chk(arr_wr_data, {d[135:72], d[63:0]});
            apb(1'b0, wcca_pkg::OFS_MODE5, 32'h0);
            chk(rd[3], exp_e);
            apb(1'b0, wcca_pkg::OFS_MULTIPURPOSE_PAGE_REG_THREE, 32'h0);
            chk(rd[0], exp_e);
            apb(1'b1, wcca_pkg::OFS_MODE5, 32'h0);
            apb(1'b1, wcca_pkg::OFS_MULTIPURPOSE_PAGE_REG_THREE, 32'h0);
            // A clean retry must leave the cleared bit low
            if (exp_e) i_ctrl.send(d, cases[i][5:0], 2'h0, 3'h0);
            repeat (4) @(posedge sys_clk);
            apb(1'b0, wcca_pkg::OFS_MODE5, 32'h0);
            chk(rd[3], 1'b0);
        end
        test_done();
    end
endmodule : wcca_top_tb
